// ### src/r8d_core.sv
// Instruction decode and execute core of an 8-bit RISC controller.
module r8d_core
   import r8d_pkg::*;
#(
   parameter int STACK_DEPTH = 8
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [12:0] i_pm_data,
   input wire logic [7:0] i_ctl_rdata,
   input wire logic i_wake,
   output logic [12:0] o_pm_addr,
   output logic [3:0] o_ctl_addr,
   output logic [7:0] o_ctl_wdata,
   output logic o_ctl_we,
   output logic [7:0] o_cont,
   output logic o_int_en,
   output logic o_wdt_clr,
   output logic o_osc_stop
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   // The stack pointer wraps, so only a power of two depth works.
   if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
   begin : g_chk
      $error("STACK_DEPTH must be a power of two of at least 2");
   end

   // ***************************************************************
   // State
   // ***************************************************************
   r8d_state_e state_q, state_d;
   logic [PC_W-1:0] pc_q, pc_d, pm_addr_q, pm_addr_d, pc_inc;
   logic [12:0] ir_q, ir_d;
   logic [7:0] acc_q, acc_d, status_q, status_d, rsr_q, rsr_d, cont_q, cont_d;
   logic [SP_W-1:0] sp_q, sp_d, sp_dec;
   logic int_en_q, int_en_d, wdt_clr_q, wdt_clr_d, osc_stop_q, osc_stop_d;
   logic ctl_we_q, ctl_we_d;
   logic [3:0] ctl_addr_q, ctl_addr_d;
   logic [7:0] ctl_wdata_q, ctl_wdata_d;
   logic wake_m_q, wake_s_q;
   logic [7:0] regs_q [BANKS*BANK_REGS];
   logic [PC_W-1:0] stack_q [STACK_DEPTH];
   logic mem_we, stack_we, redirect;
   logic [5:0] eff;
   logic [7:0] mem_addr, rval, bmask, alu_a, alu_r, alu_y;
   logic alu_c, alu_dc;
   r8d_alu_e alu_op;
   logic wr_acc, wr_reg, upd_z, upd_cdc, upd_c, skip_z, skip_t;
   logic op_call, op_jmp, op_ret, op_iret, op_lret, op_tjmp, op_sleep, op_wdtc;
   logic op_cwr, op_crd, op_contw, op_contr, op_eni, op_disi;

   assign pc_inc = pc_q + 13'h0001;
   assign sp_dec = sp_q - SP_W'(1);
   // Indirect access goes through the low six bits of the select register.
   assign eff = (ir_q[5:0] == ADDR_IND) ? rsr_q[5:0] : ir_q[5:0];
   assign mem_addr = {rsr_q[BK_HI:BK_LO], eff};

   r8d_alu u_alu (
      .i_op(alu_op),
      .i_a(alu_a),
      .i_r(alu_r),
      .i_c(status_q[ST_C]),
      .i_dc(status_q[ST_DC]),
      .o_y(alu_y),
      .o_c(alu_c),
      .o_dc(alu_dc)
   );

   // ***************************************************************
   // Decode
   // ***************************************************************
   // Operand read and decode of the held instruction word.
   always_comb
   begin
      case (eff)
         ADDR_IND: rval = 8'h00;
         ADDR_PC: rval = pc_inc[7:0];
         ADDR_STATUS: rval = status_q;
         ADDR_RSR: rval = rsr_q;
         default: rval = regs_q[mem_addr];
      endcase
      bmask = 8'h01 << ir_q[8:6];
      alu_op = ALU_PASS;
      alu_a = acc_q;
      alu_r = rval;
      {wr_acc, wr_reg, upd_z, upd_cdc, upd_c, skip_z, skip_t} = 7'h00;
      {op_call, op_jmp, op_ret, op_iret, op_lret, op_tjmp, op_sleep, op_wdtc} = 8'h00;
      {op_cwr, op_crd, op_contw, op_contr, op_eni, op_disi} = 6'h00;
      if (ir_q[12])
      begin
         alu_r = ir_q[7:0];
         wr_acc = 1'b1;
         case (ir_q[11:8])
            4'h8: alu_op = ALU_PASS;
            4'h9: {alu_op, upd_z} = {ALU_OR, 1'b1};
            4'hA: {alu_op, upd_z} = {ALU_AND, 1'b1};
            4'hB: {alu_op, upd_z} = {ALU_XOR, 1'b1};
            4'hC: op_lret = 1'b1;
            4'hD: {alu_op, upd_z, upd_cdc} = {ALU_SUB, 2'b11};
            4'hF: {alu_op, upd_z, upd_cdc} = {ALU_ADD, 2'b11};
            default:
            begin
               wr_acc = 1'b0;
               op_call = ir_q[11:10] == 2'b00;
               op_jmp = ir_q[11:10] == 2'b01;
            end
         endcase
      end
      else if (ir_q[11])
      begin
         case (ir_q[10:9])
            2'b00: {alu_r, wr_reg} = {rval & ~bmask, 1'b1};
            2'b01: {alu_r, wr_reg} = {rval | bmask, 1'b1};
            2'b10: skip_t = (rval & bmask) == 8'h00;
            2'b11: skip_t = (rval & bmask) != 8'h00;
         endcase
      end
      else
      begin
         wr_acc = !ir_q[6];
         wr_reg = ir_q[6];
         case (ir_q[10:7])
            4'h0:
            begin
               wr_acc = 1'b0;
               alu_r = acc_q;
               if (!ir_q[6])
               begin
                  case (ir_q[5:0])
                     OP_DAA: {alu_op, wr_acc, upd_c} = {ALU_DAA, 2'b11};
                     OP_CONTW: op_contw = 1'b1;
                     OP_SLEEP: op_sleep = 1'b1;
                     OP_WDTC: op_wdtc = 1'b1;
                     OP_ENI: op_eni = 1'b1;
                     OP_DISI: op_disi = 1'b1;
                     OP_RET: op_ret = 1'b1;
                     OP_IRET: op_iret = 1'b1;
                     OP_CONTR: op_contr = 1'b1;
                     OP_TJMP: {alu_op, alu_r, upd_z, upd_cdc, op_tjmp} = {ALU_ADD, pc_inc[7:0], 3'b111};
                     default:
                     begin
                        op_cwr = ir_q[5:4] == 2'b00 && ir_q[3:0] >= IOC_MIN;
                        op_crd = ir_q[5:4] == 2'b01 && ir_q[3:0] >= IOC_MIN;
                     end
                  endcase
               end
            end
            4'h1:
            begin
               wr_acc = !ir_q[6] && ir_q[5:0] == 6'h00;
               alu_op = ALU_ZERO;
               upd_z = wr_acc | wr_reg;
            end
            4'h2: {alu_op, upd_z, upd_cdc} = {ALU_SUB, 2'b11};
            4'h3: {alu_op, upd_z} = {ALU_DEC, 1'b1};
            4'h4: {alu_op, upd_z} = {ALU_OR, 1'b1};
            4'h5: {alu_op, upd_z} = {ALU_AND, 1'b1};
            4'h6: {alu_op, upd_z} = {ALU_XOR, 1'b1};
            4'h7: {alu_op, upd_z, upd_cdc} = {ALU_ADD, 2'b11};
            4'h8: upd_z = 1'b1;
            4'h9: {alu_op, upd_z} = {ALU_COM, 1'b1};
            4'hA: {alu_op, upd_z} = {ALU_INC, 1'b1};
            4'hB: {alu_op, skip_z} = {ALU_DEC, 1'b1};
            4'hC: {alu_op, upd_c} = {ALU_ROR, 1'b1};
            4'hD: {alu_op, upd_c} = {ALU_ROL, 1'b1};
            4'hE: alu_op = ALU_SWAP;
            4'hF: {alu_op, skip_z} = {ALU_INC, 1'b1};
         endcase
      end
   end

   // ***************************************************************
   // Sequencer and execute
   // ***************************************************************
   // Fetch takes one clock and execute one; a redirect adds two idle clocks.
   always_comb
   begin
      logic [PC_W-1:0] pc_n;
      pc_n = pc_inc;
      {state_d, pc_d, pm_addr_d, ir_d, acc_d} = {state_q, pc_q, pm_addr_q, ir_q, acc_q};
      {status_d, rsr_d, cont_d, sp_d} = {status_q, rsr_q, cont_q, sp_q};
      {int_en_d, osc_stop_d, ctl_addr_d, ctl_wdata_d} = {int_en_q, osc_stop_q, ctl_addr_q, ctl_wdata_q};
      wdt_clr_d = 1'b0;
      ctl_we_d = 1'b0;
      mem_we = 1'b0;
      stack_we = 1'b0;
      redirect = 1'b0;
      unique case (state_q)
         S_FETCH:
         begin
            ir_d = i_pm_data;
            ctl_addr_d = i_pm_data[3:0];
            state_d = S_EXEC;
         end
         S_EXEC:
         begin
            if (upd_z)
               status_d[ST_Z] = alu_y == 8'h00;
            if (upd_cdc)
               {status_d[ST_DC], status_d[ST_C]} = {alu_dc, alu_c};
            if (upd_c)
               status_d[ST_C] = alu_c;
            if (wr_acc)
               acc_d = alu_y;
            if (wr_reg)
            begin
               // A register write wins over the flag update of the same step.
               case (eff)
                  ADDR_IND: ;
                  ADDR_PC: {pc_n, redirect} = {pc_q[PC_W-1:8], alu_y, 1'b1};
                  ADDR_STATUS: status_d = alu_y;
                  ADDR_RSR: rsr_d = alu_y;
                  default: mem_we = 1'b1;
               endcase
            end
            if (op_tjmp)
               {pc_n, redirect} = {pc_q[PC_W-1:8], alu_y, 1'b1};
            if ((skip_z && alu_y == 8'h00) || skip_t)
               {pc_n, redirect} = {pc_q + 13'h0002, 1'b1};
            if (op_call || op_jmp)
               {pc_n, redirect} = {status_q[ST_PS_HI:ST_PS_LO], ir_q[9:0], 1'b1};
            if (op_call)
               {stack_we, sp_d} = {1'b1, sp_q + SP_W'(1)};
            if (op_ret || op_iret || op_lret)
               {pc_n, sp_d, redirect} = {stack_q[sp_dec], sp_dec, 1'b1};
            if (op_iret || op_eni)
               int_en_d = 1'b1;
            if (op_disi)
               int_en_d = 1'b0;
            if (op_contw)
               cont_d = acc_q;
            if (op_contr)
               acc_d = cont_q;
            if (op_cwr)
               {ctl_we_d, ctl_wdata_d} = {1'b1, acc_q};
            if (op_crd)
               acc_d = i_ctl_rdata;
            if (op_sleep || op_wdtc)
               {wdt_clr_d, status_d[ST_T], status_d[ST_P]} = {2'b11, op_wdtc};
            osc_stop_d = op_sleep;
            pc_d = pc_n;
            pm_addr_d = pc_n;
            if (op_sleep)
               state_d = S_SLEEP;
            else if (redirect)
               state_d = S_WAIT1;
            else
               state_d = S_FETCH;
         end
         S_WAIT1: state_d = S_WAIT2;
         S_WAIT2: state_d = S_FETCH;
         S_SLEEP:
         begin
            if (wake_s_q)
               {osc_stop_d, state_d} = {1'b0, S_FETCH};
         end
      endcase
   end

   // Control registers.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         {state_q, pc_q, pm_addr_q, ir_q, acc_q} <= {S_FETCH, 13'h0000, 13'h0000, 13'h0000, 8'h00};
         {status_q, rsr_q, cont_q, sp_q} <= {STATUS_RST, RSR_RST, CONT_RST, SP_W'(0)};
         {int_en_q, wdt_clr_q, osc_stop_q, ctl_we_q} <= 4'h0;
         {ctl_addr_q, ctl_wdata_q, wake_m_q, wake_s_q} <= {4'h0, 8'h00, 2'b00};
      end
      else
      begin
         {state_q, pc_q, pm_addr_q, ir_q, acc_q} <= {state_d, pc_d, pm_addr_d, ir_d, acc_d};
         {status_q, rsr_q, cont_q, sp_q} <= {status_d, rsr_d, cont_d, sp_d};
         {int_en_q, wdt_clr_q, osc_stop_q, ctl_we_q} <= {int_en_d, wdt_clr_d, osc_stop_d, ctl_we_d};
         {ctl_addr_q, ctl_wdata_q, wake_m_q, wake_s_q} <= {ctl_addr_d, ctl_wdata_d, i_wake, wake_m_q};
      end
   end

   // Register file and return stack hold no reset so they map onto plain RAM.
   always_ff @(posedge i_clk)
   begin
      if (mem_we)
         regs_q[mem_addr] <= alu_y;
      if (stack_we)
         stack_q[sp_q] <= pc_inc;
   end

   assign o_pm_addr = pm_addr_q;
   assign o_ctl_addr = ctl_addr_q;
   assign o_ctl_wdata = ctl_wdata_q;
   assign o_ctl_we = ctl_we_q;
   assign o_cont = cont_q;
   assign o_int_en = int_en_q;
   assign o_wdt_clr = wdt_clr_q;
   assign o_osc_stop = osc_stop_q;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_refetch;
      state_q == S_WAIT1 ##1 state_q == S_WAIT2 ##1 state_q == S_FETCH;
   endsequence

   AST_PLAIN_ONE_CYCLE: assert property (state_q == S_EXEC && !redirect && !op_sleep |=> state_q == S_FETCH)
      else $error("plain instruction did not return to fetch");
   AST_REDIRECT_TWO_CYCLES: assert property (state_q == S_EXEC && redirect |=> s_refetch)
      else $error("redirect did not take two instruction cycles");
   AST_CALL_TARGET: assert property (state_q == S_EXEC && op_call |=>
      pc_q == {$past(status_q[7:5]), $past(ir_q[9:0])} && stack_q[$past(sp_q)] == $past(pc_inc))
      else $error("call pushed or loaded the wrong address");
   AST_TJMP_KEEP_HIGH: assert property (state_q == S_EXEC && op_tjmp |=> pc_q[12:8] == $past(pc_q[12:8]))
      else $error("table jump changed the high counter bits");
   AST_SLEEP_EFFECT: assert property (state_q == S_EXEC && op_sleep |=>
      o_osc_stop && o_wdt_clr && status_q[ST_T] && !status_q[ST_P])
      else $error("power down did not stop, clear and flag");
   AST_IRET_ENABLE: assert property (state_q == S_EXEC && op_iret |=> o_int_en && pc_q == $past(stack_q[sp_dec]))
      else $error("interrupt return failed to pop or enable");
   AST_LRET_ACC: assert property (state_q == S_EXEC && op_lret |=> acc_q == $past(ir_q[7:0]))
      else $error("literal return loaded a wrong accumulator");
   AST_SWAP_NO_FLAGS: assert property (state_q == S_EXEC && alu_op == ALU_SWAP && eff != ADDR_STATUS
      |=> status_q[2:0] == $past(status_q[2:0]))
      else $error("nibble swap changed a flag");
   AST_CWR_STROBE: assert property (state_q == S_EXEC && op_cwr |=> o_ctl_we && o_ctl_wdata == $past(acc_q) ##1 !o_ctl_we)
      else $error("control write strobe or data wrong");

endmodule : r8d_core

// ### src/r8d_pkg.sv
// Shared constants, opcodes and types of the 8-bit RISC instruction decoder.
package r8d_pkg;

   // ***************************************************************
   // Widths and sizes
   // ***************************************************************
   localparam int PC_W = 13;
   localparam int DW = 8;
   localparam int BANKS = 4;
   localparam int BANK_REGS = 64;

   // ***************************************************************
   // Register map of the operation space
   // ***************************************************************
   localparam logic [5:0] ADDR_IND = 6'h00;
   localparam logic [5:0] ADDR_PC = 6'h02;
   localparam logic [5:0] ADDR_STATUS = 6'h03;
   localparam logic [5:0] ADDR_RSR = 6'h04;
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_P = 3;
   localparam int ST_T = 4;
   localparam int ST_PS_LO = 5;
   localparam int ST_PS_HI = 7;
   localparam int BK_LO = 6;
   localparam int BK_HI = 7;
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] RSR_RST = 8'h00;
   localparam logic [7:0] CONT_RST = 8'h3F;
   localparam logic [3:0] IOC_MIN = 4'h5;

   // ***************************************************************
   // Fixed opcodes of the miscellaneous group (low six bits)
   // ***************************************************************
   localparam logic [5:0] OP_DAA = 6'h01;
   localparam logic [5:0] OP_CONTW = 6'h02;
   localparam logic [5:0] OP_SLEEP = 6'h03;
   localparam logic [5:0] OP_WDTC = 6'h04;
   localparam logic [5:0] OP_ENI = 6'h10;
   localparam logic [5:0] OP_DISI = 6'h11;
   localparam logic [5:0] OP_RET = 6'h12;
   localparam logic [5:0] OP_IRET = 6'h13;
   localparam logic [5:0] OP_CONTR = 6'h14;
   localparam logic [5:0] OP_TJMP = 6'h20;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [3:0] {
      ALU_PASS, ALU_ADD, ALU_SUB, ALU_INC, ALU_DEC, ALU_OR, ALU_AND,
      ALU_XOR, ALU_COM, ALU_ROR, ALU_ROL, ALU_SWAP, ALU_DAA, ALU_ZERO
   } r8d_alu_e;

   typedef enum logic [2:0] {S_FETCH, S_EXEC, S_WAIT1, S_WAIT2, S_SLEEP} r8d_state_e;

endpackage : r8d_pkg

// ### src/r8d_alu.sv
// Combinational arithmetic and logic unit of the instruction decoder.
module r8d_alu
   import r8d_pkg::*;
(
   input wire r8d_alu_e i_op,
   input wire logic [7:0] i_a,
   input wire logic [7:0] i_r,
   input wire logic i_c,
   input wire logic i_dc,
   output logic [7:0] o_y,
   output logic o_c,
   output logic o_dc
);

   // One result per operation; carry is "no borrow" on subtraction.
   always_comb
   begin
      logic [8:0] sum;
      logic [4:0] nib;
      sum = 9'h000;
      nib = 5'h00;
      o_y = i_r;
      o_c = i_c;
      o_dc = i_dc;
      case (i_op)
         ALU_PASS: o_y = i_r;
         ALU_ADD:
         begin
            sum = {1'b0, i_r} + {1'b0, i_a};
            nib = {1'b0, i_r[3:0]} + {1'b0, i_a[3:0]};
            o_y = sum[7:0];
            o_c = sum[8];
            o_dc = nib[4];
         end
         ALU_SUB:
         begin
            sum = {1'b0, i_r} + {1'b0, ~i_a} + 9'h001;
            nib = {1'b0, i_r[3:0]} + {1'b0, ~i_a[3:0]} + 5'h01;
            o_y = sum[7:0];
            o_c = sum[8];
            o_dc = nib[4];
         end
         ALU_INC: o_y = i_r + 8'h01;
         ALU_DEC: o_y = i_r - 8'h01;
         ALU_OR: o_y = i_a | i_r;
         ALU_AND: o_y = i_a & i_r;
         ALU_XOR: o_y = i_a ^ i_r;
         ALU_COM: o_y = ~i_r;
         ALU_ROR:
         begin
            o_y = {i_c, i_r[7:1]};
            o_c = i_r[0];
         end
         ALU_ROL:
         begin
            o_y = {i_r[6:0], i_c};
            o_c = i_r[7];
         end
         ALU_SWAP: o_y = {i_r[3:0], i_r[7:4]};
         ALU_DAA:
         begin
            // Adjust the low digit first, then the high one.
            sum = {1'b0, i_a};
            if (i_dc || (sum[3:0] > 4'h9))
               sum = sum + 9'h006;
            if (i_c || sum[8] || (sum[7:4] > 4'h9))
               sum = sum + 9'h060;
            o_y = sum[7:0];
            o_c = i_c | sum[8];
         end
         ALU_ZERO: o_y = 8'h00;
      endcase
   end

endmodule : r8d_alu

// ### sim/tb_top.sv
// Self-checking testbench of the instruction decode and execute core.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef logic [12:0] r8d_prog_t [$];
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_wake = 1'b0;
   logic [12:0] i_pm_data = 13'h0000;
   logic [7:0] i_ctl_rdata = 8'h00;
   logic [12:0] o_pm_addr;
   logic [3:0] o_ctl_addr;
   logic [7:0] o_ctl_wdata;
   logic o_ctl_we;
   logic [7:0] o_cont;
   logic o_int_en;
   logic o_wdt_clr;
   logic o_osc_stop;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int wdt_n = 0;
   logic [12:0] rom [0:255];
   logic [19:0] wr_q [$];

   // *****************************************
   // Clock, program memory and write monitor
   // *****************************************
   always #10 i_clk = ~i_clk;

   // Program words change on the falling edge so the fetch edge sees them settled.
   always @(negedge i_clk) i_pm_data <= rom[o_pm_addr[7:0]];

   // Each control write is logged with its cycle stamp, so spacing can be judged.
   always @(posedge i_clk)
   begin
      if (i_rst)
         cyc <= 0;
      else
      begin
         cyc <= cyc + 1;
         if (o_ctl_we === 1'b1) wr_q.push_back({cyc[7:0], o_ctl_addr, o_ctl_wdata});
         if (o_wdt_clr === 1'b1) wdt_n++;
      end
   end

   r8d_core #(.STACK_DEPTH(8)) uut (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pm_data(i_pm_data),
      .i_ctl_rdata(i_ctl_rdata),
      .i_wake(i_wake),
      .o_pm_addr(o_pm_addr),
      .o_ctl_addr(o_ctl_addr),
      .o_ctl_wdata(o_ctl_wdata),
      .o_ctl_we(o_ctl_we),
      .o_cont(o_cont),
      .o_int_en(o_int_en),
      .o_wdt_clr(o_wdt_clr),
      .o_osc_stop(o_osc_stop)
   );

   // *****************************************
   // Shared tasks
   // *****************************************
   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Unused memory holds jumps to themselves, so a program parks at its end.
   task automatic run(input r8d_prog_t p, input int n);
      @(negedge i_clk);
      i_rst = 1'b1;
      for (int i = 0; i < 256; i++) rom[i] = 13'h1400 | 13'(i);
      foreach (p[i]) rom[i] = p[i];
      repeat (2) @(negedge i_clk);
      wr_q.delete();
      wdt_n = 0;
      i_rst = 1'b0;
      repeat (n) @(negedge i_clk);
   endtask : run

   task automatic wr(input int i, input logic [11:0] exp);
      check("control write", exp, (i < wr_q.size()) ? wr_q[i][11:0] : 12'hXXX);
   endtask : wr

   task automatic gap(input int i, input int exp);
      check("write spacing", 12'(exp), (i + 1 < wr_q.size()) ? 12'(wr_q[i + 1][19:12] - wr_q[i][19:12]) : 12'hXXX);
   endtask : gap

   task automatic print_verdict();
      if (bad_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // *****************************************
   // Scenarios
   // *****************************************
   task automatic test_reset();
      check("cont at reset", 12'h03F, {4'h0, o_cont});
      check("int enable at reset", 12'h000, {11'h000, o_int_en});
      check("osc stop at reset", 12'h000, {11'h000, o_osc_stop});
      check("pm addr at reset", 12'h000, o_pm_addr[11:0]);
   endtask : test_reset

   // Bit set, clear and test, bank switching and an undefined word in the flow.
   // bit clears here only touch plain memory, never the status or select registers.
   task automatic test_bits();
      run('{13'h1800, 13'h0060, 13'h0BE0, 13'h0A20, 13'h0FE0, 13'h18EE, 13'h0420, 13'h0005, 13'h09E0, 13'h0C20,
            13'h0420, 13'h0006, 13'h1840, 13'h0044, 13'h1855, 13'h0060, 13'h0420, 13'h1E00, 13'h0007, 13'h1800,
            13'h0044, 13'h0420, 13'h0008}, 70);
      wr(0, 12'h581);
      wr(1, 12'h601);
      wr(2, 12'h755);
      wr(3, 12'h801);
   endtask : test_bits

   task automatic test_rotate();
      run('{13'h1881, 13'h0060, 13'h0620, 13'h0005, 13'h06A0, 13'h0006, 13'h0403, 13'h0007, 13'h183C, 13'h0060,
            13'h0720, 13'h0008, 13'h0403, 13'h0009, 13'h0660, 13'h0420, 13'h000A, 13'h06E0, 13'h0420, 13'h000B}, 60);
      wr(0, 12'h540);
      wr(1, 12'h603);
      wr(2, 12'h719);
      wr(3, 12'h8C3);
      wr(4, 12'h919);
      wr(5, 12'hA9E);
      wr(6, 12'hB3C);
   endtask : test_rotate

   // Skips and a jump, with the spacing of the writes around them.
   task automatic test_skip();
      run('{13'h1801, 13'h0060, 13'h05A0, 13'h18EE, 13'h0005, 13'h07E0, 13'h1877, 13'h0006, 13'h18FF, 13'h0060,
            13'h07A0, 13'h18EE, 13'h0007, 13'h0008, 13'h0000, 13'h0009, 13'h1412, 13'h18EE, 13'h000A}, 60);
      wr(0, 12'h500);
      wr(1, 12'h677);
      wr(2, 12'h700);
      wr(5, 12'hA00);
      gap(1, 10);
      gap(2, 2);
      gap(3, 4);
      gap(4, 6);
   endtask : test_skip

   task automatic test_call();
      run('{13'h1008, 13'h0005, 13'h1802, 13'h0020, 13'h18EE, 13'h18EE, 13'h0006, 13'h1407, 13'h1C77}, 40);
      wr(0, 12'h577);
      wr(1, 12'h602);
   endtask : test_call

   task automatic test_ctl();
      i_ctl_rdata = 8'h5A;
      run('{13'h18A5, 13'h0002, 13'h0017, 13'h000F, 13'h1006, 13'h1405, 13'h0013}, 30);
      wr(0, 12'hF5A);
      check("cont", 12'h0A5, {4'h0, o_cont});
      check("int enable", 12'h001, {11'h000, o_int_en});
   endtask : test_ctl

   task automatic test_sleep();
      run('{13'h0004, 13'h0003, 13'h18C8, 13'h0005, 13'h0403, 13'h0006}, 20);
      check("osc stop asleep", 12'h001, {11'h000, o_osc_stop});
      check("wdt clears", 12'h002, 12'(wdt_n));
      check("writes asleep", 12'h000, 12'(wr_q.size()));
      i_wake = 1'b1;
      repeat (6) @(negedge i_clk);
      i_wake = 1'b0;
      check("osc stop awake", 12'h000, {11'h000, o_osc_stop});
      repeat (20) @(negedge i_clk);
      wr(0, 12'h5C8);
      wr(1, 12'h610);
   endtask : test_sleep

   // *****************************************
   // Main sequence and watchdog
   // *****************************************
   initial
   begin
      repeat (6) @(negedge i_clk);
      test_reset();
      test_bits();
      test_rotate();
      test_skip();
      test_call();
      test_ctl();
      test_sleep();
      print_verdict();
   end

   // The tests need well under a thousand cycles; three thousand means a hang.
   initial
   begin
      repeat (3000) @(posedge i_clk);
      bad_count++;
      print_verdict();
   end
endmodule : tb_top
